// [rtl/raw_map.svh]
`ifndef RAW_MAP_SVH
`define RAW_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define RAW_R_FLAGS 4'h0
`define RAW_R_ALM_SEC 4'h2
`define RAW_R_ALM_MIN 4'h3
`define RAW_R_ALM_HR 4'h4
`define RAW_R_ALM_DATE 4'h5
`define RAW_R_INTR 4'h6
`define RAW_R_WDOG 4'h7
`define RAW_R_CTRL 4'h8
`define RAW_R_SEC 4'h9
`define RAW_R_MIN 4'hA
`define RAW_R_HR 4'hB
`define RAW_R_DAY 4'hC
`define RAW_R_DATE 4'hD
`define RAW_R_MON 4'hE
`define RAW_R_YR 4'hF
// ****************************************
// Bit positions
// ****************************************
`define RAW_B_WF 7
`define RAW_B_AF 6
`define RAW_B_W 7
`define RAW_B_R 6
`define RAW_B_OSC 7
`define RAW_B_FT 6
`define RAW_B_AE 7
`define RAW_B_ABE 5
`define RAW_B_WDS 7
`define RAW_B_AM 7
`define RAW_FT_BIT 5
// ****************************************
// Time field masks and limits (BCD)
// ****************************************
`define RAW_M_CEN 8'h3F
`define RAW_M_SEC 8'h7F
`define RAW_M_HR 8'h3F
`define RAW_M_DAY 8'h07
`define RAW_M_DATE 8'h3F
`define RAW_M_MON 8'h1F
`define RAW_M_YR 8'hFF
`define RAW_ZERO 8'h00
`define RAW_ONE 8'h01
`define RAW_MAX_SEC 8'h59
`define RAW_MAX_HR 8'h23
`define RAW_MAX_DAY 8'h07
`define RAW_MAX_MON 8'h12
`define RAW_MAX_YR 8'h99
`define RAW_MAX_CEN 8'h39
`define RAW_FEB 5'h02
`define RAW_APR 5'h04
`define RAW_JUN 5'h06
`define RAW_SEP 5'h09
`define RAW_NOV 5'h11
`define RAW_DIM_31 8'h31
`define RAW_DIM_30 8'h30
`define RAW_DIM_29 8'h29
`define RAW_DIM_28 8'h28
// ****************************************
// Reset values, modes, timing
// ****************************************
`define RAW_SEC_RST 8'h80
`define RAW_PINS_IDLE 20'hF0000
`define RAW_AM_EVERY 4'hF
`define RAW_AM_SEC 4'hE
`define RAW_AM_MIN 4'hC
`define RAW_AM_HR 4'h8
`define RAW_AM_DATE 4'h0
`define RAW_PRE_W 15
`define RAW_SIXT_W 11
`define RAW_WD_W 11
`define RAW_HOLD_W 13
`define RAW_STAB_W 4
`define RAW_CLK_NS 100
`define RAW_TRC_NS 100
`define RAW_HOLD_US 500
`endif

// [rtl/raw_pkg.sv]
package raw_pkg;
	// ****************************************
	// Shared types
	// ****************************************
	typedef logic [7:0] raw_byte_t;
	// Pin inputs sampled together
	typedef struct packed {
		logic sel_n;
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [3:0] addr;
		logic [7:0] data;
		logic osc;
		logic batt;
		logic pwrup;
		logic batt_low;
	} raw_pins_s;
	// Host access state
	typedef enum logic [2:0] {
		ACC_IDLE = 3'b001,
		ACC_READ = 3'b010,
		ACC_WRITE = 3'b100
	} raw_acc_e;
endpackage

// [rtl/raw_rtc.sv]
// What this block does
// - Chip select low, write enable and SRAM enable high reads one of 16 registers.
// - Write runs from later falling edge of select/write to earlier rising edge.
// - Seconds MSB stops oscillator when 1, runs it at 0; starts at 1.
// - Read hold freezes external registers; internal counters keep running.
// - After read hold low 500us, external updates resume within one second.
// - Write hold stops updates of 8h-Fh; clearing loads values into counters.
// - Output toggles 512Hz when FT=1, AE=0 and steering=1 or watchdog zero.
// - Frequency test bit cleared on every power application; the power-up input leaves it set.
// - Alarm registers 2h-5h hold match values; four mask bits choose the rate.
// - Undefined mask combinations behave as once per second alarm.
// - Alarm match sets alarm flag; with AE it pulls the interrupt low.
// - Stable flags address for read cycle time releases interrupt; flag clears after.
// - On battery, alarm interrupt needs both AE and ABE set.
// - AE and ABE clear during power-up; alarm still sets the flag.
// - Watchdog timeout is five-bit multiplier times 1/16, 1/4, 1 or 4 s.
// - Watchdog timeout sets its flag and interrupt until flag or watchdog access.
// - With steering bit zero, watchdog timeout drives the interrupt output.
// - Any watchdog register access restarts the count; 00h disables it.
// - Power application clears watchdog register, AE and ABE.
`include "raw_map.svh"
`timescale 1ns/100ps
`default_nettype none
module raw_rtc #(
	parameter int HOLD_CYC = `RAW_HOLD_US * 1000 / `RAW_CLK_NS
) (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic i_rtc_sel_n,
	input wire logic i_sram_en_n,
	input wire logic i_wr_en_n,
	input wire logic i_out_en_n,
	input wire logic [3:0] i_addr,
	input wire raw_pkg::raw_byte_t i_data,
	output raw_pkg::raw_byte_t o_data,
	output logic o_data_oe,
	input wire logic i_osc_32k,
	input wire logic i_on_battery,
	input wire logic i_power_up,
	input wire logic i_batt_low,
	output logic o_irq_freq_out_n,
	output logic o_irq_freq_oe
);
	import raw_pkg::*;

	localparam int TRC_CYC_RAW = (`RAW_TRC_NS + `RAW_CLK_NS - 1) / `RAW_CLK_NS;
	localparam int TRC_CYC = (TRC_CYC_RAW < 1) ? 1 : TRC_CYC_RAW;

	// ****************************************
	// Functions
	// ****************************************
	// BCD step with wrap; bit 8 is the carry out
	function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
		if (v >= hi)
			bcd_step = {1'b1, lo};
		else if (v[3:0] == 4'h9)
			bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			bcd_step = {1'b0, v + 8'h01};
	endfunction

	// Time bits of each clock register
	function automatic logic [7:0] tmask(input logic [3:0] idx);
		case (idx)
			`RAW_R_CTRL: tmask = `RAW_M_CEN;
			`RAW_R_SEC, `RAW_R_MIN: tmask = `RAW_M_SEC;
			`RAW_R_HR: tmask = `RAW_M_HR;
			`RAW_R_DAY: tmask = `RAW_M_DAY;
			`RAW_R_DATE: tmask = `RAW_M_DATE;
			`RAW_R_MON: tmask = `RAW_M_MON;
			`RAW_R_YR: tmask = `RAW_M_YR;
			default: tmask = `RAW_ZERO;
		endcase
	endfunction

	// Last date of the month, leap years by two-digit BCD year
	function automatic logic [7:0] days_in(input logic [4:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
			`RAW_FEB: days_in = leap ? `RAW_DIM_29 : `RAW_DIM_28;
			`RAW_APR, `RAW_JUN, `RAW_SEP, `RAW_NOV: days_in = `RAW_DIM_30;
			default: days_in = `RAW_DIM_31;
		endcase
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	raw_pins_s pin_raw;
	raw_pins_s pin_m;
	raw_pins_s pin_s;
	logic osc_d;

	assign pin_raw = '{sel_n: i_rtc_sel_n, ce_n: i_sram_en_n, we_n: i_wr_en_n, oe_n: i_out_en_n,
		addr: i_addr, data: i_data, osc: i_osc_32k, batt: i_on_battery, pwrup: i_power_up,
		batt_low: i_batt_low};

	// Two flops on every pin
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			pin_m <= `RAW_PINS_IDLE;
			pin_s <= `RAW_PINS_IDLE;
			osc_d <= 1'b0;
		end
		else
		begin
			pin_m <= pin_raw;
			pin_s <= pin_m;
			osc_d <= pin_s.osc;
		end
	end

	// ****************************************
	// Register storage
	// ****************************************
	raw_byte_t ext [0:15];
	raw_byte_t cnt [8:15];
	logic af;
	logic wf;

	// ****************************************
	// Host access decode
	// ****************************************
	raw_acc_e state;
	raw_acc_e next_state;
	logic [3:0] acc_addr;
	logic [3:0] wr_addr;
	raw_byte_t wr_data;
	logic [`RAW_STAB_W-1:0] stab;
	logic rel;
	wire acc_ok = ~pin_s.batt & ~pin_s.pwrup;
	wire rd_cond = acc_ok & ~pin_s.sel_n & pin_s.ce_n & pin_s.we_n;
	wire wr_cond = acc_ok & ~pin_s.sel_n & pin_s.ce_n & ~pin_s.we_n;
	wire rd_done = (state == ACC_READ) & (~rd_cond | pin_s.addr != acc_addr);
	wire wr_done = (state == ACC_WRITE) & ~wr_cond;
	wire acc_done = rd_done | wr_done;
	wire done_addr_is_flags = (state == ACC_READ ? acc_addr : wr_addr) == `RAW_R_FLAGS;
	wire done_addr_is_wdog = (state == ACC_READ ? acc_addr : wr_addr) == `RAW_R_WDOG;
	wire rel_hit = (state != ACC_IDLE) & (pin_s.addr == `RAW_R_FLAGS) & (pin_s.addr == acc_addr)
		& (stab >= `RAW_STAB_W'(TRC_CYC)) & (~pin_s.oe_n | ~pin_s.we_n);
	wire flags_clr = acc_done & done_addr_is_flags & (rel | rel_hit);
	wire wd_access = acc_done & done_addr_is_wdog;
	wire w_fall = wr_done & (wr_addr == `RAW_R_CTRL) & ext[`RAW_R_CTRL][`RAW_B_W] & ~wr_data[`RAW_B_W];
	wire raw_byte_t rd_mux = (pin_s.addr == `RAW_R_FLAGS)
		? {wf, af, 1'b0, pin_s.batt_low, 4'h0} : ext[pin_s.addr];

	// Access sequencing; write enable ends a read so outputs turn off
	always_comb
	begin
		next_state = state;
		case (state)
			ACC_IDLE: next_state = wr_cond ? ACC_WRITE : (rd_cond ? ACC_READ : ACC_IDLE);
			ACC_READ: next_state = wr_cond ? ACC_WRITE : (rd_cond ? ACC_READ : ACC_IDLE);
			ACC_WRITE: next_state = wr_cond ? ACC_WRITE : ACC_IDLE;
			default: next_state = ACC_IDLE;
		endcase
	end

	// Access state, captured write, address stability and release latch
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			state <= ACC_IDLE;
			acc_addr <= 4'h0;
			wr_addr <= 4'h0;
			wr_data <= 8'h00;
			stab <= '0;
			rel <= 1'b0;
			o_data <= 8'h00;
			o_data_oe <= 1'b0;
		end
		else
		begin
			state <= next_state;
			acc_addr <= pin_s.addr;
			if (wr_cond)
			begin
				wr_addr <= pin_s.addr;
				wr_data <= pin_s.data;
			end
			if (state == ACC_IDLE || pin_s.addr != acc_addr)
				stab <= '0;
			else if (stab != '1)
				stab <= stab + `RAW_STAB_W'(1);
			rel <= acc_done ? 1'b0 : (rel | rel_hit);
			o_data <= rd_mux;
			o_data_oe <= (next_state == ACC_READ) & ~pin_s.oe_n;
		end
	end

	// ****************************************
	// Oscillator prescaler and hold timing
	// ****************************************
	logic [`RAW_PRE_W-1:0] pre;
	logic sec_tick_d;
	logic [`RAW_HOLD_W-1:0] hold_cnt;
	wire osc_run = ~ext[`RAW_R_SEC][`RAW_B_OSC];
	wire osc_edge = pin_s.osc & ~osc_d & osc_run;
	wire sec_tick = osc_edge & (&pre);
	wire sixt_tick = osc_edge & (&pre[`RAW_SIXT_W-1:0]);
	wire hold_done = hold_cnt >= `RAW_HOLD_W'(HOLD_CYC);
	wire upd_now = sec_tick_d & hold_done & ~ext[`RAW_R_CTRL][`RAW_B_R] & ~ext[`RAW_R_CTRL][`RAW_B_W];

	// Prescaler and hold-release counter
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			pre <= '0;
			sec_tick_d <= 1'b0;
			hold_cnt <= '0;
		end
		else
		begin
			if (osc_edge)
				pre <= pre + `RAW_PRE_W'(1);
			sec_tick_d <= sec_tick;
			if (ext[`RAW_R_CTRL][`RAW_B_R])
				hold_cnt <= '0;
			else if (!hold_done)
				hold_cnt <= hold_cnt + `RAW_HOLD_W'(1);
		end
	end

	// ****************************************
	// Internal timekeeping counters
	// ****************************************
	logic [8:0] st_sec, st_min, st_hr, st_day, st_date, st_mon, st_yr, st_cen;
	assign st_sec = bcd_step(cnt[`RAW_R_SEC], `RAW_ZERO, `RAW_MAX_SEC);
	assign st_min = bcd_step(cnt[`RAW_R_MIN], `RAW_ZERO, `RAW_MAX_SEC);
	assign st_hr = bcd_step(cnt[`RAW_R_HR], `RAW_ZERO, `RAW_MAX_HR);
	assign st_day = bcd_step(cnt[`RAW_R_DAY], `RAW_ONE, `RAW_MAX_DAY);
	assign st_date = bcd_step(cnt[`RAW_R_DATE], `RAW_ONE, days_in(cnt[`RAW_R_MON][4:0], cnt[`RAW_R_YR]));
	assign st_mon = bcd_step(cnt[`RAW_R_MON], `RAW_ONE, `RAW_MAX_MON);
	assign st_yr = bcd_step(cnt[`RAW_R_YR], `RAW_ZERO, `RAW_MAX_YR);
	assign st_cen = bcd_step(cnt[`RAW_R_CTRL], `RAW_ZERO, `RAW_MAX_CEN);
	wire c_min = st_sec[8];
	wire c_hr = c_min & st_min[8];
	wire c_day = c_hr & st_hr[8];
	wire c_mon = c_day & st_date[8];
	wire c_yr = c_mon & st_mon[8];
	wire c_cen = c_yr & st_yr[8];

	// Counters load from the external set when write hold drops
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			for (int i = 8; i < 16; i++)
				cnt[i] <= 8'h00;
		end
		else if (w_fall)
		begin
			for (int i = 9; i < 16; i++)
				cnt[i] <= ext[i] & tmask(4'(i));
			cnt[`RAW_R_CTRL] <= wr_data & `RAW_M_CEN;
		end
		else if (sec_tick)
		begin
			cnt[`RAW_R_SEC] <= st_sec[7:0];
			if (c_min)
				cnt[`RAW_R_MIN] <= st_min[7:0];
			if (c_hr)
				cnt[`RAW_R_HR] <= st_hr[7:0];
			if (c_day)
			begin
				cnt[`RAW_R_DAY] <= st_day[7:0];
				cnt[`RAW_R_DATE] <= st_date[7:0];
			end
			if (c_mon)
				cnt[`RAW_R_MON] <= st_mon[7:0];
			if (c_yr)
				cnt[`RAW_R_YR] <= st_yr[7:0];
			if (c_cen)
				cnt[`RAW_R_CTRL] <= st_cen[7:0];
		end
	end

	// ****************************************
	// External register set
	// ****************************************
	// Host writes win over updates; power-up keeps alarm enables clear
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			for (int i = 0; i < 16; i++)
				ext[i] <= 8'h00;
			ext[`RAW_R_SEC] <= `RAW_SEC_RST;
		end
		else
		begin
			if (wr_done && wr_addr != `RAW_R_FLAGS)
				ext[wr_addr] <= wr_data;
			else if (upd_now)
			begin
				for (int i = 8; i < 16; i++)
					ext[i] <= (ext[i] & ~tmask(4'(i))) | (cnt[i] & tmask(4'(i)));
			end
			if (pin_s.pwrup)
			begin
				ext[`RAW_R_INTR][`RAW_B_AE] <= 1'b0;
				ext[`RAW_R_INTR][`RAW_B_ABE] <= 1'b0;
			end
		end
	end

	// ****************************************
	// Alarm match
	// ****************************************
	wire [3:0] am = {ext[`RAW_R_ALM_DATE][`RAW_B_AM], ext[`RAW_R_ALM_HR][`RAW_B_AM],
		ext[`RAW_R_ALM_MIN][`RAW_B_AM], ext[`RAW_R_ALM_SEC][`RAW_B_AM]};
	wire am_ok = am == `RAW_AM_EVERY || am == `RAW_AM_SEC || am == `RAW_AM_MIN || am == `RAW_AM_HR
		|| am == `RAW_AM_DATE;
	wire [3:0] am_eff = am_ok ? am : `RAW_AM_EVERY;
	wire m_sec = cnt[`RAW_R_SEC] == (ext[`RAW_R_ALM_SEC] & `RAW_M_SEC);
	wire m_min = cnt[`RAW_R_MIN] == (ext[`RAW_R_ALM_MIN] & `RAW_M_SEC);
	wire m_hr = cnt[`RAW_R_HR] == (ext[`RAW_R_ALM_HR] & `RAW_M_HR);
	wire m_date = cnt[`RAW_R_DATE] == (ext[`RAW_R_ALM_DATE] & `RAW_M_DATE);
	wire alarm_ev = sec_tick_d & (am_eff[0] | m_sec) & (am_eff[1] | m_min)
		& (am_eff[2] | m_hr) & (am_eff[3] | m_date);

	// ****************************************
	// Watchdog
	// ****************************************
	logic [`RAW_WD_W-1:0] wd_cnt;
	wire raw_byte_t wd_reg = ext[`RAW_R_WDOG];
	wire [`RAW_WD_W-1:0] wd_limit = `RAW_WD_W'(wd_reg[6:2]) << {wd_reg[1:0], 1'b0};
	wire wd_en = wd_limit != '0;
	wire wd_ev = sixt_tick & wd_en & ~wd_access & (wd_cnt + `RAW_WD_W'(1) == wd_limit);

	// Timeout counter in sixteenths of a second
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			wd_cnt <= '0;
		else if (wd_access || !wd_en || wd_ev)
			wd_cnt <= '0;
		else if (sixt_tick)
			wd_cnt <= wd_cnt + `RAW_WD_W'(1);
	end

	// Sticky flags; a new event wins over a clear in the same cycle
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			af <= 1'b0;
			wf <= 1'b0;
		end
		else
		begin
			af <= alarm_ev | (af & ~flags_clr);
			wf <= wd_ev | (wf & ~flags_clr & ~wd_access);
		end
	end

	// ****************************************
	// Interrupt / frequency test output
	// ****************************************
	wire ae = ext[`RAW_R_INTR][`RAW_B_AE];
	wire wdog_steer = wd_reg[`RAW_B_WDS];
	wire irq_on = ((af & ae & (~pin_s.batt | ext[`RAW_R_INTR][`RAW_B_ABE]))
		| (wf & ~wdog_steer)) & ~rel & ~rel_hit;
	wire ft_on = ext[`RAW_R_DAY][`RAW_B_FT] & ~ae & (wdog_steer | wd_reg == 8'h00) & osc_run;

	// Open-drain pull low while active
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_irq_freq_oe <= 1'b0;
		else
			o_irq_freq_oe <= irq_on | (ft_on & ~pre[`RAW_FT_BIT]);
	end

	assign o_irq_freq_out_n = 1'b0; // Only ever pulls low
endmodule
`default_nettype wire

// [bench/raw_rtc_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module raw_rtc_props (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic i_rtc_sel_n,
	input wire logic i_sram_en_n,
	input wire logic i_wr_en_n,
	input wire logic i_out_en_n,
	input wire logic [3:0] i_addr,
	input wire logic i_on_battery,
	input wire logic i_power_up,
	input wire logic o_data_oe,
	input wire logic o_irq_freq_out_n,
	input wire logic o_irq_freq_oe
);
	// ****************************************
	// Port relations
	// ****************************************
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_arst_n);
	// Decoded host read cycles
	wire rd_c = !i_rtc_sel_n && i_sram_en_n && i_wr_en_n && !i_out_en_n && !i_on_battery && !i_power_up;
	wire fl_c = rd_c && i_addr == 4'h0;
	a_read_drives: assert property (rd_c [*6] |=> o_data_oe)
		else $error("read cycle without data drive");
	a_write_releases: assert property ((!i_wr_en_n) [*4] |=> !o_data_oe)
		else $error("data driven during write");
	a_sram_releases: assert property ((!i_sram_en_n) [*6] |=> !o_data_oe)
		else $error("data driven with memory enabled");
	a_backup_releases: assert property (i_on_battery [*6] |=> !o_data_oe)
		else $error("data driven on backup");
	a_powerup_releases: assert property (i_power_up [*6] |=> !o_data_oe)
		else $error("data driven in power-up");
	a_flags_release: assert property (fl_c [*8] |=> !o_irq_freq_oe)
		else $error("interrupt held during flags read");
	a_pin_low_only: assert property (o_irq_freq_out_n == 1'b0)
		else $error("open-drain pin value not low");
	a_reset_quiet: assert property ($rose(i_arst_n) |-> !o_data_oe && !o_irq_freq_oe)
		else $error("outputs active after power application");
	c_flags_read: cover property (fl_c [*8]);
	c_irq_low: cover property ($rose(o_irq_freq_oe));
	c_write: cover property ((!i_wr_en_n) [*4]);
endmodule
bind raw_rtc raw_rtc_props u_props (
	.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_rtc_sel_n(i_rtc_sel_n),
	.i_sram_en_n(i_sram_en_n), .i_wr_en_n(i_wr_en_n), .i_out_en_n(i_out_en_n),
	.i_addr(i_addr), .i_on_battery(i_on_battery), .i_power_up(i_power_up),
	.o_data_oe(o_data_oe), .o_irq_freq_out_n(o_irq_freq_out_n), .o_irq_freq_oe(o_irq_freq_oe)
);
`default_nettype wire

// [bench/raw_host.sv]
`timescale 1ns/100ps
`default_nettype none
module raw_host (
	input wire logic i_clk,
	input wire raw_pkg::raw_byte_t i_data,
	output logic o_sel_n,
	output logic o_sram_en_n,
	output logic o_wr_en_n,
	output logic o_out_en_n,
	output logic [3:0] o_addr,
	output raw_pkg::raw_byte_t o_data
);
	import raw_pkg::*;
	// ****************************************
	// Host processor bus cycles
	// ****************************************
	// Idle bus, memory side parked
	initial
	begin
		o_sel_n = 1'b1;
		o_sram_en_n = 1'b1;
		o_wr_en_n = 1'b1;
		o_out_en_n = 1'b1;
		o_addr = 4'hF;
		o_data = 8'hA5;
	end
	// Write: address settles first, select, then write enable
	task automatic wr(input logic [3:0] a, input raw_byte_t d);
		@(negedge i_clk);
		o_addr = a;
		o_data = d;
		o_out_en_n = 1'b1;
		@(negedge i_clk);
		o_sel_n = 1'b0;
		@(negedge i_clk);
		o_wr_en_n = 1'b0;
		repeat (4) @(negedge i_clk);
		o_wr_en_n = 1'b1;
		@(negedge i_clk);
		o_sel_n = 1'b1;
		o_data = ~d;
		repeat (3) @(negedge i_clk);
	endtask
	// Read: hold address and enables long enough for data to settle
	task automatic rd(input logic [3:0] a, output raw_byte_t d);
		@(negedge i_clk);
		o_addr = a;
		o_sel_n = 1'b0;
		o_out_en_n = 1'b0;
		repeat (10) @(negedge i_clk);
		d = i_data;
		o_out_en_n = 1'b1;
		o_sel_n = 1'b1;
		repeat (3) @(negedge i_clk);
	endtask
	// Clashing enables: memory and clock selected together with output enable
	task automatic clash;
		@(negedge i_clk);
		o_sel_n = 1'b0;
		o_sram_en_n = 1'b0;
		o_out_en_n = 1'b0;
		repeat (8) @(negedge i_clk);
		o_sel_n = 1'b1;
		o_sram_en_n = 1'b1;
		o_out_en_n = 1'b1;
		repeat (3) @(negedge i_clk);
	endtask
endmodule
`default_nettype wire

// [bench/raw_rtc_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module raw_rtc_tb;
	import raw_pkg::*;
	logic i_sys_clk, i_arst_n, i_osc_32k, i_on_battery, i_power_up, i_batt_low;
	logic sel_n, sram_en_n, wr_en_n, out_en_n, data_oe, irq_n, irq_oe;
	logic [3:0] addr;
	raw_byte_t wdata, rdata, d;
	int err_count, samples_checked, n;
	logic [3:0] ta [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h0};
	raw_byte_t tw [6] = '{8'h5A, 8'h15, 8'h2A, 8'h13, 8'h31, 8'hFF};
	raw_byte_t te [6] = '{8'h5A, 8'h15, 8'h2A, 8'h13, 8'h31, 8'h00};
	// ****************************************
	// Device, host and clocks
	// ****************************************
	raw_rtc #(.HOLD_CYC(20)) DUT (
		.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_rtc_sel_n(sel_n), .i_sram_en_n(sram_en_n),
		.i_wr_en_n(wr_en_n), .i_out_en_n(out_en_n), .i_addr(addr), .i_data(wdata), .o_data(rdata),
		.o_data_oe(data_oe), .i_osc_32k(i_osc_32k), .i_on_battery(i_on_battery),
		.i_power_up(i_power_up), .i_batt_low(i_batt_low), .o_irq_freq_out_n(irq_n),
		.o_irq_freq_oe(irq_oe)
	);
	raw_host host (
		.i_clk(i_sys_clk), .i_data(rdata), .o_sel_n(sel_n), .o_sram_en_n(sram_en_n),
		.o_wr_en_n(wr_en_n), .o_out_en_n(out_en_n), .o_addr(addr), .o_data(wdata)
	);
	// System clock, 100 ns
	initial
	begin
		i_sys_clk = 1'b0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end
	// Sped-up oscillator, four system cycles a period, edges on falling clock
	initial
	begin
		i_osc_32k = 1'b0;
		forever #200 i_osc_32k = ~i_osc_32k;
	end
	// Compare and count
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Wait for the interrupt pin drive to reach a level, bounded
	task automatic wait_oe(input logic v, input int lim, output int c);
		c = 0;
		while (irq_oe !== v && c < lim)
		begin
			@(negedge i_sys_clk);
			c++;
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Hang guard
	initial
	begin
		#(80000 * 100);
		err_count++;
		test_done;
	end
	// ****************************************
	// Test sequence
	// ****************************************
	initial
	begin
		i_arst_n = 1'b0;
		i_on_battery = 1'b0;
		i_power_up = 1'b0;
		i_batt_low = 1'b0;
		repeat (6) @(negedge i_sys_clk);
		i_arst_n = 1'b1;
		repeat (3) @(negedge i_sys_clk);
		for (int i = 0; i < 6; i++)
		begin
			host.wr(ta[i], tw[i]);
			host.rd(ta[i], d);
			chk("table", d, te[i]);
		end
		// Start oscillator, watchdog four sixteenths, restart midway
		host.wr(4'h8, 8'h80);
		host.wr(4'h9, 8'h00);
		host.wr(4'h8, 8'h00);
		host.wr(4'h7, 8'h10);
		repeat (12500) @(negedge i_sys_clk);
		host.rd(4'h7, d);
		repeat (22500) @(negedge i_sys_clk);
		chk("wd early", {7'h00, irq_oe}, 8'h00);
		wait_oe(1'b1, 12000, n);
		chk("wd fire", {7'h00, irq_oe}, 8'h01);
		host.rd(4'h0, d);
		chk("wd flag", d, 8'h80);
		chk("wd release", {7'h00, irq_oe}, 8'h00);
		host.rd(4'h0, d);
		chk("flag clear", d, 8'h00);
		host.wr(4'h7, 8'h00);
		// Frequency test: 512 Hz is 128 cycles a half period here
		host.wr(4'h8, 8'h80);
		host.wr(4'hC, 8'h40);
		host.wr(4'h8, 8'h00);
		wait_oe(1'b0, 600, n);
		wait_oe(1'b1, 600, n);
		wait_oe(1'b0, 600, n);
		chk("ft high", 8'(n), 8'h80);
		wait_oe(1'b1, 600, n);
		chk("ft low", 8'(n), 8'h80);
		host.wr(4'h6, 8'h80);
		repeat (20) @(negedge i_sys_clk);
		wait_oe(1'b1, 600, n);
		chk("ae mask", {7'h00, irq_oe}, 8'h00);
		// Writes refused on backup; battery low shows in flags
		i_on_battery = 1'b1;
		repeat (3) @(negedge i_sys_clk);
		host.wr(4'h1, 8'h00);
		i_on_battery = 1'b0;
		i_batt_low = 1'b1;
		host.rd(4'h1, d);
		chk("backup wr", d, 8'h5A);
		host.rd(4'h0, d);
		chk("batt low", d, 8'h10);
		// Memory enable low during a clock read keeps the data bus off
		fork
			host.clash;
			begin
				repeat (7) @(negedge i_sys_clk);
				chk("clash oe", {7'h00, data_oe}, 8'h00);
			end
		join
		// Power-up transition clears both alarm enables
		host.wr(4'h6, 8'hA0);
		i_power_up = 1'b1;
		repeat (10) @(negedge i_sys_clk);
		i_power_up = 1'b0;
		host.rd(4'h6, d);
		chk("pwrup", d, 8'h00);
		// Second power application
		host.wr(4'h7, 8'h10);
		i_arst_n = 1'b0;
		repeat (6) @(negedge i_sys_clk);
		i_arst_n = 1'b1;
		host.rd(4'h7, d);
		chk("rst wdog", d, 8'h00);
		host.rd(4'h9, d);
		chk("rst sec", d, 8'h80);
		host.rd(4'hC, d);
		chk("rst ft", d, 8'h00);
		test_done;
	end
endmodule
`default_nettype wire
